// ### fbd_defs.vh
// Purpose: constants for the flash bus host controller
// Assumes: 100 MHz clock, pin levels abstracted to logic levels
// Notes:   high voltage levels appear as separate enable outputs
`ifndef FBD_DEFS_VH
`define FBD_DEFS_VH
`define FBD_CLK_NS        10
`define FBD_ACC_NS        100
`define FBD_ACC_CYC       ((`FBD_ACC_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)
`define FBD_WP_NS         40
`define FBD_WP_CYC        ((`FBD_WP_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)
`define FBD_RP_NS         500
`define FBD_RP_CYC        ((`FBD_RP_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)
`define FBD_OP_READ       3'h0
`define FBD_OP_WRITE      3'h1
`define FBD_OP_ACCEL      3'h2
`define FBD_OP_PROTECT    3'h3
`define FBD_OP_UNPROTECT  3'h4
`define FBD_OP_RESET      3'h5
`define FBD_SECT_LSB      15
`define FBD_PROT_A6       6
`endif

// ### fbd_host.v
// Purpose: host controller driving the parallel pins of a page-mode NOR flash
// Assumes: one op at a time; pins sampled through two flip-flops
// Notes:   no command sequencing here, only single bus cycles
// How it works
// R1: command register has no address; host reaches it only via write cycles
// R2: device latches each written command with its address and data
// R3: read drives chip select and output enable low, write enable high
// R4: chip select selects device; data appears only with output enable low
// R5: word mode decodes down to A0, byte mode down to low address bit
// R6: sector index comes from address bits top down to bit 15
// R7: lock pin low keeps outermost sectors protected on the device
// R8: lock pin high leaves outer sectors to stored protection state
// R9: device ships with all sector groups unprotected
// R10: width select high means sixteen-bit word transfers
// R11: width select low means eight-bit byte transfers on low lines
// R12: byte mode leaves data lines 8 to 14 floating
// R13: byte mode uses data line 15 as lowest address bit
// R14: protect: high reset level, ce low, oe high, we low, fixed address bits
// R15: unprotect: same levels but address bit 6 high
// R16: high reset level with lock high temporarily unprotects groups
// R17: accelerated program: write cycle with boost level on boost pin
// R18: write drives write enable and chip select low, output enable high
// R19: output enable high means device floats its data pins
// R20: reset low for minimum pulse aborts and returns to array read
// R21: after reset the device reads array data without any command
`timescale 1ns/100ps
`default_nettype none
`include "fbd_defs.vh"
module fbd_host #(
    parameter AW = 24,
    parameter ACC_CYC = `FBD_ACC_CYC,
    parameter WP_CYC = `FBD_WP_CYC,
    parameter RP_CYC = `FBD_RP_CYC
) (
    // clock and reset
    input  wire          clk,
    input  wire          sys_rst,
    // user request
    input  wire          req_valid,
    input  wire [2:0]    req_op,
    input  wire [AW-1:0] req_addr,
    input  wire [15:0]   req_wdata,
    input  wire          req_byte_mode,
    input  wire          req_lock,
    input  wire          req_temp_unprot,
    output reg           req_ready,
    output reg           rsp_valid,
    output reg  [15:0]   rsp_rdata,
    // flash pins
    output reg           chip_sel_n,
    output reg           out_en_n,
    output reg           wr_en_n,
    output reg           reset_n,
    output reg           high_protect_level,
    output reg           width_sel,
    output reg           lock_or_boost_pin,
    output reg           high_boost_level,
    output reg  [AW-1:0] addr,
    output reg  [14:0]   dq_out,
    output reg  [14:0]   dq_oe,
    output reg           top_data_or_low_addr,
    output reg           top_oe,
    input  wire [15:0]   dq_in
);
    localparam S_IDLE = 3'b001;
    localparam S_BUSY = 3'b010;
    localparam S_DONE = 3'b100;
    localparam CW = 16;

    reg [2:0]    state;
    reg [CW-1:0] cnt;
    reg [2:0]    op;
    reg [15:0]   sync1;
    reg [15:0]   sync2;

    // request taken this edge, same test the sequencer uses in idle
    wire         take;
    // protect and unprotect both need the reset pin at the high level
    wire         hv_req;
    wire         hv_busy;

    // decode of the request and of the cycle in flight
    assign take    = (state == S_IDLE) && req_valid && req_ready;
    assign hv_req  = (req_op == `FBD_OP_PROTECT) || (req_op == `FBD_OP_UNPROTECT);
    assign hv_busy = (state == S_BUSY) && (cnt > 16'h0001) &&
                     ((op == `FBD_OP_PROTECT) || (op == `FBD_OP_UNPROTECT));

    // pin timing notes for whoever picks this up:
    // - every strobe changes on one edge, so the device sees
    //   address, data and control settle together
    // - the high reset level must rise with the strobes, not a
    //   cycle later, or the first cycle of a protect looks like
    //   a plain write to the device
    // - it drops on the same edge as the strobes; holding it
    //   longer would leave the device in temporary unprotect
    // - read data is sampled at the end of the window through
    //   the two-flop synchroniser, so the window must cover the
    //   access time plus two cycles of synchroniser delay; the
    //   window is ACC_CYC cycles, the access time alone
    // - byte mode shifts the user address right by one and puts
    //   the byte select on the top data line
    // - a pin reset leaves chip select high; the device ignores
    //   the bus for the whole pulse anyway
    // - only one request is ever in flight; req_ready is the
    //   only backpressure and no request is refused
    // - the lock pin takes the user level at each take edge and
    //   holds it; protect and unprotect cycles and temporary unprotect force it high

    // pin inputs pass two flops first
    always @(posedge clk) begin
        sync1 <= dq_in;
        sync2 <= sync1;
    end

    // bus cycle sequencer
    always @(posedge clk) begin
        if (sys_rst) begin
            state <= S_IDLE;
            cnt <= 16'h0000;
            op <= 3'h0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            wr_en_n <= 1'b1;
            reset_n <= 1'b1;
            high_protect_level <= 1'b0;
            width_sel <= 1'b1;
            lock_or_boost_pin <= 1'b1;
            high_boost_level <= 1'b0;
            addr <= {AW{1'b0}};
            dq_out <= 15'h0000;
            dq_oe <= 15'h0000;
            top_data_or_low_addr <= 1'b0;
            top_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            // temp unprotect is a standing level, not a cycle
            // rises with the strobes at the take edge, falls with them
            high_protect_level <= req_temp_unprot | (take && hv_req) | hv_busy; // [R16] [R14]
            if (req_temp_unprot)
                lock_or_boost_pin <= 1'b1; // [R16]
            case (state)
                S_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        op <= req_op;
                        state <= S_BUSY;
                        width_sel <= ~req_byte_mode; // [R10] [R11]
                        // byte mode: bit 0 of user address rides on dq15
                        addr <= req_byte_mode ? {1'b0, req_addr[AW-1:1]} : req_addr; // [R5]
                        dq_out <= req_wdata[14:0];
                        top_data_or_low_addr <= req_byte_mode ? req_addr[0] : req_wdata[15]; // [R13]
                        top_oe <= req_byte_mode || req_op != `FBD_OP_READ; // [R13]
                        lock_or_boost_pin <= req_lock | req_temp_unprot; // [R7] [R8]
                        high_boost_level <= 1'b0;
                        case (req_op)
                            `FBD_OP_READ: begin
                                cnt <= ACC_CYC[CW-1:0];
                                chip_sel_n <= 1'b0; // [R3] [R4]
                                out_en_n <= 1'b0;
                                wr_en_n <= 1'b1;
                                dq_oe <= 15'h0000;
                            end
                            `FBD_OP_RESET: begin
                                cnt <= RP_CYC[CW-1:0];
                                reset_n <= 1'b0; // [R20] [R21]
                                chip_sel_n <= 1'b1;
                                top_oe <= 1'b0;
                            end
                            default: begin
                                // writes keep output enable high so the device floats [R19]
                                cnt <= WP_CYC[CW-1:0];
                                chip_sel_n <= 1'b0; // [R18] [R1] [R2]
                                out_en_n <= 1'b1;
                                wr_en_n <= 1'b0;
                                // byte mode: dq8..14 left floating
                                dq_oe <= req_byte_mode ? 15'h00ff : 15'h7fff; // [R12]
                                if (req_op == `FBD_OP_ACCEL) begin
                                    high_boost_level <= 1'b1; // [R17]
                                end
                                if (req_op == `FBD_OP_PROTECT || req_op == `FBD_OP_UNPROTECT) begin
                                    lock_or_boost_pin <= 1'b1; // [R14]
                                    // keep sector index, force low address pattern
                                    addr[`FBD_SECT_LSB-1:0] <= 15'h0002; // [R6] [R14]
                                    addr[`FBD_PROT_A6] <= (req_op == `FBD_OP_UNPROTECT); // [R15]
                                end
                            end
                        endcase
                    end
                end
                S_BUSY: begin
                    if (cnt > 16'h0001) begin
                        cnt <= cnt - 16'h0001;
                    end else begin
                        state <= S_DONE;
                        if (op == `FBD_OP_READ)
                            rsp_rdata <= width_sel ? sync2 : {8'h00, sync2[7:0]};
                        chip_sel_n <= 1'b1;
                        out_en_n <= 1'b1;
                        wr_en_n <= 1'b1;
                        reset_n <= 1'b1;
                        dq_oe <= 15'h0000;
                        top_oe <= 1'b0;
                        high_boost_level <= 1'b0;
                    end
                end
                S_DONE: begin
                    rsp_valid <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    // device ships unprotected, nothing to do here [R9]
endmodule
`default_nettype wire

// ### fbd_host_assertions.sv
// Purpose: pin-level checks on the flash host
// Assumes: read window of ACC_CYC cycles
// Notes:   bound to every fbd_host instance
`timescale 1ns/100ps
`default_nettype none
module fbd_host_assertions #(parameter int AW = 24, parameter int ACC_CYC = 10) (
    // watched host ports
    input wire logic          clk, sys_rst, req_valid, req_ready, rsp_valid, chip_sel_n, out_en_n,
    input wire logic          wr_en_n, high_protect_level, lock_or_boost_pin, high_boost_level,
    input wire logic [2:0]    req_op,
    input wire logic [AW-1:0] addr
);
    localparam int RSP = ACC_CYC + 2;
    wire logic tk = req_valid && req_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // strobe levels of plain reads and writes, and read answer timing
    property p_rd; !chip_sel_n && !out_en_n |-> wr_en_n; endproperty
    a_rd: assert property (p_rd) else $error("write strobe inside read");
    property p_rsp; tk && req_op == 3'h0 |-> ##RSP rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("read answer off time");
    property p_wr; !wr_en_n |-> !chip_sel_n && out_en_n; endproperty
    a_wr: assert property (p_wr) else $error("bad write strobes");
    // protect and unprotect cycles must carry the fixed address pattern, boosted programs the boost level
    property p_prot; tk && req_op == 3'h3 |=> high_protect_level && lock_or_boost_pin && !wr_en_n
        && out_en_n && !chip_sel_n && !addr[6] && addr[3:0] == 4'h2; endproperty
    a_prot: assert property (p_prot) else $error("bad protect cycle");
    property p_unp; tk && req_op == 3'h4 |=> high_protect_level && !wr_en_n && addr[6]
        && addr[3:0] == 4'h2; endproperty
    a_unp: assert property (p_unp) else $error("bad unprotect cycle");
    property p_acc; tk && req_op == 3'h2 |=> high_boost_level && !wr_en_n && out_en_n; endproperty
    a_acc: assert property (p_acc) else $error("bad boosted program");
    c_wr: cover property (tk && req_op == 3'h1);
    c_rst: cover property (tk && req_op == 3'h5);
    c_prot: cover property (tk && req_op == 3'h3);
endmodule
bind fbd_host fbd_host_assertions #(.AW(AW), .ACC_CYC(ACC_CYC)) i_fbd_host_assertions (.clk(clk),
    .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .high_protect_level(high_protect_level),
    .lock_or_boost_pin(lock_or_boost_pin), .high_boost_level(high_boost_level), .req_op(req_op), .addr(addr));
`default_nettype wire

// ### fbd_flash_model.sv
// Purpose: behavioural flash device facing the host
// Assumes: sixteen-word array, address wraps
// Notes:   released lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module fbd_flash_model (
    // pins from the host
    input wire logic        clk, chip_sel_n, out_en_n, wr_en_n, reset_n, width_sel, top_data_or_low_addr,
    input wire logic [3:0]  addr,
    input wire logic [14:0] dq_out,
    // pins to the host
    output wire logic [15:0] dq_in
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [15:0] val;
    wire logic   drv = !chip_sel_n && !out_en_n && reset_n;
    // array readable from power-up, writes go straight into the array at the address
    initial for (int i = 0; i < 16; i++) mem[i] = 16'ha5c0 + 16'(i);
    // byte mode picks a half by the low address bit
    assign val = width_sel ? mem[addr] : {8'h00, top_data_or_low_addr ? mem[addr][15:8] : mem[addr][7:0]};
    assign dq_in[7:0] = drv ? val[7:0] : ~last[7:0];
    assign dq_in[15:8] = drv && width_sel ? val[15:8] : ~last[15:8];
    // data taken while the write strobe is low
    always @(posedge clk) begin
        if (drv) last <= val;
        if (!wr_en_n && !chip_sel_n && reset_n) mem[addr] <= {top_data_or_low_addr, dq_out};
    end
endmodule
`default_nettype wire

// ### fbd_host_tb.sv
// Purpose: directed checks of the flash host at its pins
// Assumes: default host timing, lock pin held high
// Notes:   one request at a time
`timescale 1ns/100ps
`default_nettype none
module fbd_host_tb;
    logic        clk = 0, sys_rst = 1, req_valid = 0, bm = 0;
    logic [2:0]  req_op = 0;
    logic [23:0] req_addr = 0;
    logic [15:0] wd = 0, rd;
    int          mismatches = 0, checks_done = 0;
    wire logic   req_ready, rsp_valid, ce_n, oe_n, we_n, rst_n, ws, tda;
    wire logic [23:0] fa;
    wire logic [15:0] rdata, dq_in;
    wire logic [14:0] dq_out;
    fbd_host i_fbd_host (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(wd), .req_byte_mode(bm), .req_lock(1'b1), .req_temp_unprot(1'b0),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rdata), .chip_sel_n(ce_n), .out_en_n(oe_n),
        .wr_en_n(we_n), .reset_n(rst_n), .high_protect_level(), .width_sel(ws), .lock_or_boost_pin(),
        .high_boost_level(), .addr(fa), .dq_out(dq_out), .dq_oe(), .top_data_or_low_addr(tda), .top_oe(),
        .dq_in(dq_in));
    fbd_flash_model i_fbd_flash_model (.clk(clk), .chip_sel_n(ce_n), .out_en_n(oe_n), .wr_en_n(we_n),
        .reset_n(rst_n), .width_sel(ws), .top_data_or_low_addr(tda), .addr(fa[3:0]), .dq_out(dq_out),
        .dq_in(dq_in));
    initial forever #5 clk = ~clk;
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // one request, held until taken, then wait for the answer
    task automatic op(logic [2:0] o, logic [23:0] a, logic [15:0] d, logic b);
        int n;
        @(posedge clk) #1 req_op = o;
        req_addr = a;
        wd = d;
        bm = b;
        req_valid = 1;
        // look at ready only once it has settled, then let the take edge pass
        while (req_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1 req_valid = 0;
        for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(posedge clk) #1;
        chk("rsp_valid", {15'h0, rsp_valid}, 16'h1);
        rd = rdata;
    endtask
    task t_boot; op(0, 24'h3, 0, 0); chk("boot read", rd, 16'ha5c3); endtask
    task t_wr;
        op(1, 24'h5, 16'h1234, 0);
        op(0, 24'h5, 0, 0);
        chk("write back", rd, 16'h1234);
        op(0, 24'h6, 0, 0);
        chk("other word", rd, 16'ha5c6);
    endtask
    task t_byte;
        op(0, 24'hb, 0, 1);
        chk("high byte", rd, 16'h0012);
        op(0, 24'ha, 0, 1);
        chk("low byte", rd, 16'h0034);
    endtask
    task t_hv;
        for (int o = 2; o < 5; o++) op(3'(o), 24'h188000, 16'h00ff, 0);
        op(0, 24'h0, 0, 0);
        chk("boosted word", rd, 16'h00ff);
    endtask
    task t_rst; op(5, 0, 0, 0); op(0, 24'h7, 0, 0); chk("read after reset", rd, 16'ha5c7); endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 sys_rst = 0;
        t_boot;
        t_wr;
        t_byte;
        t_hv;
        t_rst;
        results;
    end
    // cut a hang short, far beyond the roughly 180 cycles needed
    initial begin
        #20000 mismatches++;
        results;
    end
endmodule
`default_nettype wire
